// >>> bench/priority_service_and_status_logic_tb_top.sv
// Self-checking bench for the priority service core.
// Assumes the host model drives the bus; reads are checked by a monitor.
`default_nettype none
module priority_service_and_status_logic_tb_top import psl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, rst, chipSelectN, readStrobeN, writeStrobeN;
    logic portSelectLine, acknowledgeStrobeN, dataOutEnable, intRequest;
    logic fourthInitWrite, autoCompletionSelect, seen;
    logic [7:0] dataIn, dataOut, requestSet, m;
    logic [2:0] ackLevel;
    logic [7:0] expQ[$];
    int miscompares, comparisons;
    psl_host host (.ref_clk, .chipSelectN, .readStrobeN, .writeStrobeN,
        .portSelectLine, .dataIn, .acknowledgeStrobeN);
    priority_service_core dut (.ref_clk, .rst, .chipSelectN, .readStrobeN,
        .writeStrobeN, .portSelectLine, .dataIn, .dataOut, .dataOutEnable,
        .acknowledgeStrobeN, .threePulseMode(1'b0), .requestSet,
        .initStart(1'b0), .fourthInitWrite, .autoCompletionSelect,
        .intRequest, .ackLevel);
    ////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] want);
        comparisons++;
        if (got !== want) begin
            miscompares++;
            $display("unexpected at %0t: byte %h want %h", $time, got, want);
        end
    endtask
    task automatic chkLevel(input logic [2:0] got, input logic [2:0] want);
        comparisons++;
        if (got !== want) begin
            miscompares++;
            $display("unexpected at %0t: level %h want %h", $time, got, want);
        end
    endtask
    task automatic chkBit(input logic got, input logic want);
        comparisons++;
        if (got !== want) begin
            miscompares++;
            $display("unexpected at %0t: request %b want %b", $time, got, want);
        end
    endtask
    task automatic rd(input logic p, input logic [7:0] e);
        expQ.push_back(e);
        host.rd(p);
    endtask
    task automatic pulse(input logic [7:0] r, input logic f);
        @(negedge ref_clk);
        {requestSet, fourthInitWrite, autoCompletionSelect} = {r, f, f};
        @(negedge ref_clk);
        {requestSet, fourthInitWrite} = 9'h000;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Only the first settled cycle of each read is compared
    always @(negedge ref_clk) begin
        if (dataOutEnable !== 1'b1)
            seen <= 1'b0;
        else if (!seen) begin
            seen <= 1'b1;
            chk(dataOut, expQ.size() > 0 ? expQ.pop_front() : 8'hxx);
        end
    end
    initial begin
        #100us;
        miscompares++;
        print_verdict();
    end
    initial begin
        {rst, seen, requestSet, fourthInitWrite, autoCompletionSelect} = 12'h800;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        m = 8'($urandom(32'h59ed));
        host.wr(1'b1, m);
        rd(1'b1, m);
        host.wr(1'b1, 8'h00);
        pulse(8'h28, 1'b0);
        rd(1'b0, 8'h28);
        chkBit(intRequest, 1'b1);
        host.ack();
        chkLevel(ackLevel, 3'h3);
        chkBit(intRequest, 1'b0);
        host.ack();
        host.wr(1'b0, 8'h0b);
        rd(1'b0, 8'h08);
        rd(1'b0, 8'h08);
        host.wr(1'b0, 8'h68);
        chkBit(intRequest, 1'b1);
        host.wr(1'b0, 8'h48);
        chkBit(intRequest, 1'b0);
        // One controller here, so each done is issued once
        host.wr(1'b0, 8'h20);
        rd(1'b0, 8'h00);
        host.wr(1'b0, 8'h0c);
        rd(1'b0, 8'h85);
        rd(1'b0, 8'h20);
        host.wr(1'b0, 8'h65);
        rd(1'b0, 8'h00);
        pulse(8'h80, 1'b1);
        host.ack();
        host.ack();
        rd(1'b0, 8'h00);
        host.wr(1'b0, 8'hc4);
        pulse(8'h28, 1'b1);
        host.wr(1'b0, 8'h0c);
        rd(1'b0, 8'h85);
        print_verdict();
    end
endmodule // priority_service_and_status_logic_tb_top
`default_nettype wire

// >>> bench/psl_host.sv
// Host processor model: bus reads, writes and acknowledge pulses.
// Assumes the core samples every strobe on the rising edge of ref_clk.
`default_nettype none
module psl_host (
    input  wire logic       ref_clk,
    output logic            chipSelectN,
    output logic            readStrobeN,
    output logic            writeStrobeN,
    output logic            portSelectLine,
    output logic      [7:0] dataIn,
    output logic            acknowledgeStrobeN
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {chipSelectN, readStrobeN, writeStrobeN} = 3'h7;
        {acknowledgeStrobeN, portSelectLine, dataIn} = 10'h200;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic wr(input logic p, input logic [7:0] d);
        cyc(1);
        {chipSelectN, writeStrobeN, portSelectLine, dataIn} = {2'h0, p, d};
        cyc(2);
        {chipSelectN, writeStrobeN} = 2'h3;
        // Released bus must not keep showing the written byte
        dataIn = ~d;
        cyc(2);
    endtask
    task automatic rd(input logic p);
        cyc(1);
        {chipSelectN, readStrobeN, portSelectLine} = {2'h0, p};
        cyc(3);
        {chipSelectN, readStrobeN} = 2'h3;
        cyc(2);
    endtask
    task automatic ack();
        cyc(1);
        acknowledgeStrobeN = 1'b0;
        cyc(2);
        acknowledgeStrobeN = 1'b1;
        cyc(2);
    endtask
endmodule // psl_host
`default_nettype wire

// >>> rtl/priority_pick.sv
// Finds the highest priority set bit of a level vector under rotation.
// Assumes lowest names the level that currently has lowest priority.
`default_nettype none

module priority_pick (
    input  wire logic [7:0] vec,
    input  wire logic [2:0] lowest,
    output logic            found,
    output logic      [2:0] level
);

    ////////////////////////////////////////////////////////////////////////
    // Walk from lowest rank to highest so the last hit wins
    always_comb begin
        logic [2:0] idx;
        idx   = 3'h0;
        found = 1'b0;
        level = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            idx = lowest + 3'(i + 1);
            if (vec[idx]) begin
                found = 1'b1;
                level = idx;
            end
        end
    end

endmodule // priority_pick

`default_nettype wire

// >>> rtl/priority_service_core.sv
// Service completion, rotation, masking, polling and status readback.
// Assumes strobes synchronous to ref_clk; request pulses come from an
// outside edge or level detector, init pulses from the init decoder.
`default_nettype none

//
// Contract
// - Auto completion does a non-specific done at final acknowledge trailing edge.
// - Auto completion mode stays until the fourth init word is written again.
// - Non-specific done clears the highest set in-service bit.
// - Specific done clears the in-service bit of the given level.
// - In selective mask mode, non-specific done skips masked levels.
// - Under rotation the serviced level becomes lowest priority.
// - Rotate on non-specific done clears highest bit and makes it lowest.
// - Auto-completion rotation is enabled and disabled by priority commands.
// - Set priority makes given level lowest, touches no in-service bit.
// - Rotate on specific done clears given level and makes it lowest.
// - Each mask bit inhibits only its own request line.
// - In selective mask mode all unmasked levels can interrupt.
// - Read mode word enters or leaves selective mask mode when enabled.
// - After poll command, next read acts as acknowledge.
// - Poll answer has bit 7 for pending and level in bits 2:0.
// - Interrupt state is frozen from poll write to the read.
// - Request register ignores mask; acknowledge clears highest request.
// - Read mode word selects request or in-service register for reads.
// - Status selection is kept across reads; request register after init.
// - Reads with the port line high return the mask register.
// - Poll plus register read in one word: next read returns poll.
// - After init level 0 is highest and level 7 lowest.
// - Nested mode blocks same and lower priority requests.
module priority_service_core (
    input  wire logic                        ref_clk,
    input  wire logic                        rst,
    input  wire logic                        chipSelectN,
    input  wire logic                        readStrobeN,
    input  wire logic                        writeStrobeN,
    input  wire logic                        portSelectLine,
    input  wire logic [psl_pkg::BYTE_W-1:0]  dataIn,
    output logic      [psl_pkg::BYTE_W-1:0]  dataOut,
    output logic                             dataOutEnable,
    input  wire logic                        acknowledgeStrobeN,
    input  wire logic                        threePulseMode,
    input  wire logic [psl_pkg::NUM_LEVELS-1:0] requestSet,
    input  wire logic                        initStart,
    input  wire logic                        fourthInitWrite,
    input  wire logic                        autoCompletionSelect,
    output logic                             intRequest,
    output logic      [psl_pkg::LEVEL_W-1:0] ackLevel
);
    import psl_pkg::*;

    logic [7:0] pend_ff;
    logic [7:0] svc_ff;
    logic [7:0] chMask_ff;
    logic [7:0] deferred_ff;
    logic [2:0] lowest_ff;
    logic       selMask_ff;
    logic       readSel_ff;
    logic       pollPending_ff;
    logic       autoMode_ff;
    logic       rotateAuto_ff;
    logic [1:0] ackCount_ff;
    logic [7:0] dataOut_ff;
    logic       dataOutEnable_ff;
    logic       intRequest_ff;
    logic [2:0] ackLevel_ff;

    logic [2:0] fallEv;
    logic [2:0] riseEv;
    logic [7:0] reqCand;
    logic [7:0] doneVec;
    logic       reqFound;
    logic [2:0] reqLevel;
    logic       doneFound;
    logic [2:0] doneLevel;
    logic [2:0] reqRank;
    logic [2:0] doneRank;
    logic       wantInt;
    logic       wrEv;
    logic       rdEv;
    logic       maskWr;
    logic       pcwWr;
    logic       rmwWr;
    logic [2:0] cmd;
    logic [2:0] tgt;
    logic       rmwEnable;
    logic       rmwSelMask;
    logic       pollRead;
    logic       ackLead;
    logic       ackTrail;
    logic [1:0] lastPulse;
    logic       firstAck;
    logic       finalTrail;
    logic       autoDone;
    logic       grantValid;
    logic [2:0] grantLevel;
    logic [7:0] svcClr;
    logic       rotateEn;
    logic [2:0] rotateTo;
    logic [7:0] pendSet;

    ////////////////////////////////////////////////////////////////////////
    // Strobe edges and decode
    strobe_edge #(
        .WIDTH (3)
    ) u_edges (
        .ref_clk (ref_clk),
        .rst     (rst),
        .lineN   ({acknowledgeStrobeN, writeStrobeN, readStrobeN}),
        .fall    (fallEv),
        .rise    (riseEv)
    );

    assign rdEv      = fallEv[0] & ~chipSelectN;
    assign wrEv      = fallEv[1] & ~chipSelectN;
    assign ackLead   = fallEv[2];
    assign ackTrail  = riseEv[2];
    assign maskWr    = wrEv & portSelectLine;
    assign pcwWr     = wrEv & ~portSelectLine
                     & (dataIn[KIND_HI_BIT:KIND_LO_BIT] == KIND_PRIORITY);
    assign rmwWr     = wrEv & ~portSelectLine
                     & (dataIn[KIND_HI_BIT:KIND_LO_BIT] == KIND_READ_MODE);
    assign cmd       = dataIn[PCW_CMD_HI_BIT:PCW_CMD_LO_BIT];
    assign tgt       = dataIn[PCW_LEVEL_HI_BIT:0];
    assign rmwEnable = dataIn[RMW_ENABLE_BIT];
    assign rmwSelMask = dataIn[RMW_SEL_MASK_BIT];
    assign pollRead  = rdEv & pollPending_ff;
    assign lastPulse = threePulseMode ? ACK_PULSES_THREE : ACK_PULSES_TWO;
    assign firstAck  = ackLead & (ackCount_ff == 2'h0);
    assign finalTrail = ackTrail & (ackCount_ff == lastPulse);
    assign autoDone  = finalTrail & autoMode_ff & doneFound;

    ////////////////////////////////////////////////////////////////////////
    // Priority resolution
    assign reqCand = pend_ff & ~chMask_ff;
    // Masked in-service levels are skipped in selective mask mode
    assign doneVec = selMask_ff ? (svc_ff & ~chMask_ff) : svc_ff;

    priority_pick u_req (
        .vec    (reqCand),
        .lowest (lowest_ff),
        .found  (reqFound),
        .level  (reqLevel)
    );

    priority_pick u_done (
        .vec    (doneVec),
        .lowest (lowest_ff),
        .found  (doneFound),
        .level  (doneLevel)
    );

    assign reqRank  = reqLevel - (lowest_ff + 3'h1);
    assign doneRank = doneLevel - (lowest_ff + 3'h1);
    // Equal rank means same level in service, which blocks it
    assign wantInt  = reqFound
                    & (selMask_ff | ~doneFound | (reqRank < doneRank));

    // Acknowledge takes the best request; none pending gives the default
    assign grantValid = (firstAck & reqFound) | (pollRead & wantInt);
    assign grantLevel = reqLevel;

    ////////////////////////////////////////////////////////////////////////
    // Service completion and rotation requests
    always_comb begin
        svcClr   = 8'h00;
        rotateEn = 1'b0;
        rotateTo = lowest_ff;
        if (pcwWr) begin
            case (cmd)
                CMD_NONSPEC_DONE: begin
                    if (doneFound) svcClr[doneLevel] = 1'b1;
                end
                CMD_SPEC_DONE: begin
                    svcClr[tgt] = 1'b1;
                end
                CMD_ROT_NONSPEC: begin
                    if (doneFound) begin
                        svcClr[doneLevel] = 1'b1;
                        rotateEn = 1'b1;
                        rotateTo = doneLevel;
                    end
                end
                CMD_ROT_SPEC: begin
                    svcClr[tgt] = 1'b1;
                    rotateEn = 1'b1;
                    rotateTo = tgt;
                end
                CMD_SET_PRIORITY: begin
                    rotateEn = 1'b1;
                    rotateTo = tgt;
                end
                default: begin
                end
            endcase
        end else if (autoDone) begin
            svcClr[doneLevel] = 1'b1;
            rotateEn = rotateAuto_ff;
            rotateTo = doneLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // In-service register; a grant in the same cycle wins over a clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            svc_ff <= 8'h00;
        end else if (initStart) begin
            svc_ff <= 8'h00;
        end else begin
            svc_ff <= (svc_ff & ~svcClr)
                    | (grantValid ? (8'h01 << grantLevel) : 8'h00);
        end
    end

    // Requests arriving while frozen are held back, not lost
    assign pendSet = pollPending_ff ? 8'h00 : (requestSet | deferred_ff);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend_ff     <= 8'h00;
            deferred_ff <= 8'h00;
        end else if (initStart) begin
            pend_ff     <= 8'h00;
            deferred_ff <= 8'h00;
        end else begin
            pend_ff <= (pend_ff & ~(grantValid ? (8'h01 << grantLevel) : 8'h00))
                    | pendSet;
            deferred_ff <= pollPending_ff ? (deferred_ff | requestSet)
                                          : 8'h00;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lowest_ff <= LOWEST_RESET;
        end else if (initStart) begin
            lowest_ff <= LOWEST_RESET;
        end else if (rotateEn) begin
            lowest_ff <= rotateTo;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rotateAuto_ff <= 1'b0;
        end else if (initStart) begin
            rotateAuto_ff <= 1'b0;
        end else if (pcwWr && cmd == CMD_ROT_AUTO_ON) begin
            rotateAuto_ff <= 1'b1;
        end else if (pcwWr && cmd == CMD_ROT_AUTO_OFF) begin
            rotateAuto_ff <= 1'b0;
        end
    end

    // Only a fresh fourth init word changes the completion mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            autoMode_ff <= 1'b0;
        end else if (fourthInitWrite) begin
            autoMode_ff <= autoCompletionSelect;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mask register and read mode state
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            chMask_ff <= MASK_RESET;
        end else if (initStart) begin
            chMask_ff <= MASK_RESET;
        end else if (maskWr) begin
            chMask_ff <= dataIn;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            selMask_ff <= 1'b0;
            readSel_ff <= 1'b0;
        end else if (initStart) begin
            selMask_ff <= 1'b0;
            readSel_ff <= 1'b0;
        end else if (rmwWr) begin
            if (rmwEnable) selMask_ff <= rmwSelMask;
            if (dataIn[RMW_READ_BIT]) readSel_ff <= dataIn[RMW_SEL_BIT];
        end
    end

    // A poll write in the same cycle as a read cannot happen on one bus
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pollPending_ff <= 1'b0;
        end else if (initStart) begin
            pollPending_ff <= 1'b0;
        end else if (rmwWr && dataIn[RMW_POLL_BIT]) begin
            pollPending_ff <= 1'b1;
        end else if (rdEv) begin
            pollPending_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acknowledge sequence
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ackCount_ff <= 2'h0;
            ackLevel_ff <= DEFAULT_LEVEL;
        end else if (initStart) begin
            ackCount_ff <= 2'h0;
        end else begin
            if (finalTrail) begin
                ackCount_ff <= 2'h0;
            end else if (ackLead && ackCount_ff != lastPulse) begin
                ackCount_ff <= ackCount_ff + 2'h1;
            end
            if (firstAck) begin
                ackLevel_ff <= reqFound ? reqLevel : DEFAULT_LEVEL;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data and processor request
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dataOut_ff <= 8'h00;
        end else if (rdEv) begin
            if (pollPending_ff) begin
                dataOut_ff <= {wantInt, 4'h0, reqLevel};
            end else if (portSelectLine) begin
                dataOut_ff <= chMask_ff;
            end else begin
                dataOut_ff <= readSel_ff ? svc_ff : pend_ff;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            dataOutEnable_ff <= 1'b0;
        end else begin
            dataOutEnable_ff <= ~readStrobeN & ~chipSelectN;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            intRequest_ff <= 1'b0;
        end else if (!pollPending_ff) begin
            intRequest_ff <= wantInt;
        end
    end

    assign dataOut       = dataOut_ff;
    assign dataOutEnable = dataOutEnable_ff;
    assign intRequest    = intRequest_ff;
    assign ackLevel      = ackLevel_ff;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_nonspec_clear;
        @(posedge ref_clk) disable iff (rst)
        pcwWr && cmd == CMD_NONSPEC_DONE && doneFound && !grantValid
        |=> !svc_ff[$past(doneLevel)];
    endproperty
    a_nonspec_clear: assert property (p_nonspec_clear)
        else $error("non-specific done left its bit set");

    property p_spec_clear;
        @(posedge ref_clk) disable iff (rst)
        pcwWr && cmd == CMD_SPEC_DONE && !grantValid |=> !svc_ff[$past(tgt)];
    endproperty
    a_spec_clear: assert property (p_spec_clear)
        else $error("specific done left its bit set");

    property p_set_priority;
        @(posedge ref_clk) disable iff (rst)
        pcwWr && cmd == CMD_SET_PRIORITY && !grantValid && !initStart
        |=> lowest_ff == $past(tgt) && $stable(svc_ff);
    endproperty
    a_set_priority: assert property (p_set_priority)
        else $error("set priority wrong or touched in-service bits");

    property p_rot_nonspec;
        @(posedge ref_clk) disable iff (rst)
        pcwWr && cmd == CMD_ROT_NONSPEC && doneFound && !initStart
        |=> lowest_ff == $past(doneLevel);
    endproperty
    a_rot_nonspec: assert property (p_rot_nonspec)
        else $error("rotate on done did not make level lowest");

    property p_mask_write;
        @(posedge ref_clk) disable iff (rst)
        maskWr && !initStart |=> chMask_ff == $past(dataIn);
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write not stored");

    property p_sel_mask_mode;
        @(posedge ref_clk) disable iff (rst)
        rmwWr && rmwEnable && !initStart |=> selMask_ff == $past(rmwSelMask);
    endproperty
    a_sel_mask_mode: assert property (p_sel_mask_mode)
        else $error("selective mask mode not updated");

    property p_mask_read;
        @(posedge ref_clk) disable iff (rst)
        rdEv && portSelectLine && !pollPending_ff
        |=> dataOut_ff == $past(chMask_ff);
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("port line read did not return mask");

    property p_poll_freeze;
        @(posedge ref_clk) disable iff (rst)
        $past(pollPending_ff) |-> $stable(intRequest_ff);
    endproperty
    a_poll_freeze: assert property (p_poll_freeze)
        else $error("request output moved while poll pending");

    property p_poll_answer;
        @(posedge ref_clk) disable iff (rst)
        pollRead |=> dataOut_ff[POLL_FLAG_BIT] == $past(wantInt)
                  && !pollPending_ff;
    endproperty
    a_poll_answer: assert property (p_poll_answer)
        else $error("poll answer flag wrong");

    property p_auto_done;
        @(posedge ref_clk) disable iff (rst)
        autoDone && !pcwWr && !initStart |=> !svc_ff[$past(doneLevel)];
    endproperty
    a_auto_done: assert property (p_auto_done)
        else $error("auto completion did not clear in-service bit");

    c_poll_read:  cover property (@(posedge ref_clk) disable iff (rst)
                                  pollRead && wantInt);
    c_auto_done:  cover property (@(posedge ref_clk) disable iff (rst)
                                  autoDone && rotateAuto_ff);
    c_first_ack:  cover property (@(posedge ref_clk) disable iff (rst)
                                  firstAck && reqFound);
    c_sel_int:    cover property (@(posedge ref_clk) disable iff (rst)
                                  selMask_ff && doneFound && wantInt);

endmodule // priority_service_core

`default_nettype wire

// >>> rtl/psl_pkg.sv
// Constants shared by the priority service and status logic.
// Assumes one 100 MHz clock and bus strobes already synchronous to it.
`default_nettype none

package psl_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int          NUM_LEVELS       = 8;
    localparam int          LEVEL_W          = 3;
    localparam int          BYTE_W           = 8;

    // Command word kind, chosen by data bits 4:3 with the port line low
    localparam int          KIND_HI_BIT      = 4;
    localparam int          KIND_LO_BIT      = 3;
    localparam logic [1:0]  KIND_PRIORITY    = 2'h0;
    localparam logic [1:0]  KIND_READ_MODE   = 2'h1;

    // Priority command word fields: rotate, level select, done, level
    localparam int          PCW_CMD_HI_BIT   = 7;
    localparam int          PCW_CMD_LO_BIT   = 5;
    localparam int          PCW_LEVEL_HI_BIT = 2;
    localparam logic [2:0]  CMD_ROT_AUTO_OFF = 3'h0;
    localparam logic [2:0]  CMD_NONSPEC_DONE = 3'h1;
    localparam logic [2:0]  CMD_NO_OP        = 3'h2;
    localparam logic [2:0]  CMD_SPEC_DONE    = 3'h3;
    localparam logic [2:0]  CMD_ROT_AUTO_ON  = 3'h4;
    localparam logic [2:0]  CMD_ROT_NONSPEC  = 3'h5;
    localparam logic [2:0]  CMD_SET_PRIORITY = 3'h6;
    localparam logic [2:0]  CMD_ROT_SPEC     = 3'h7;

    // Read mode command word fields
    localparam int          RMW_ENABLE_BIT   = 6;
    localparam int          RMW_SEL_MASK_BIT = 5;
    localparam int          RMW_POLL_BIT     = 2;
    localparam int          RMW_READ_BIT     = 1;
    localparam int          RMW_SEL_BIT      = 0;

    // Poll answer layout
    localparam int          POLL_FLAG_BIT    = 7;

    // Reset values
    localparam logic [2:0]  LOWEST_RESET     = 3'h7;
    localparam logic [7:0]  MASK_RESET       = 8'h00;
    localparam logic [2:0]  DEFAULT_LEVEL    = 3'h7;

    // Acknowledge pulses per sequence
    localparam logic [1:0]  ACK_PULSES_TWO   = 2'h2;
    localparam logic [1:0]  ACK_PULSES_THREE = 2'h3;

endpackage

`default_nettype wire

// >>> rtl/strobe_edge.sv
// Leading and trailing edge detection for active-low strobes.
// Assumes the strobes are synchronous to ref_clk.
`default_nettype none

module strobe_edge #(
    parameter int WIDTH = 3
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] lineN,
    output logic      [WIDTH-1:0] fall,
    output logic      [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] lineN_ff;

    ////////////////////////////////////////////////////////////////////////
    // Idle level of every strobe is high
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lineN_ff <= '1;
        end else begin
            lineN_ff <= lineN;
        end
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_edge
        assign fall[i] = lineN_ff[i] & ~lineN[i];
        assign rise[i] = ~lineN_ff[i] & lineN[i];
    end

endmodule // strobe_edge

`default_nettype wire
